// >>> verilog/pwm_fault_pkg.sv
// constants shared by the pwm fault and capture blocks
package pwm_fault_pkg;
  localparam int          COUNT_W       = 16;
  localparam int          FILT_W        = 4;
  localparam logic [15:0] COUNT_MAX     = 16'hffff;
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  // ramp modes
  localparam logic [1:0]  RAMP_SINGLE   = 2'h0;
  localparam logic [1:0]  RAMP_TWO      = 2'h1;
  localparam logic [1:0]  RAMP_ALT      = 2'h2;
  // halt modes
  localparam logic [1:0]  HALT_OFF      = 2'h0;
  localparam logic [1:0]  HALT_HW       = 2'h1;
  localparam logic [1:0]  HALT_SW       = 2'h2;
  // capture actions
  localparam logic [2:0]  PLAIN_FAULT_CAPTURE_NONE     = 3'h0;
  localparam logic [2:0]  PLAIN_FAULT_CAPTURE_PLAIN    = 3'h1;
  localparam logic [2:0]  PLAIN_FAULT_CAPTURE_MIN      = 3'h2;
  localparam logic [2:0]  PLAIN_FAULT_CAPTURE_MAX      = 3'h3;
  localparam logic [2:0]  PLAIN_FAULT_CAPTURE_LOCAL_MINIMUM_NOTIFY   = 3'h4;
  localparam logic [2:0]  PLAIN_FAULT_CAPTURE_LOCAL_MAXIMUM_NOTIFY   = 3'h5;
  localparam logic [2:0]  PLAIN_FAULT_CAPTURE_LOCEXT   = 3'h6;
  localparam logic [2:0]  PLAIN_FAULT_CAPTURE_STAMP    = 3'h7;
  // counter halt states
  typedef enum logic [0:0] {st_count, st_halt} halt_state_type;
endpackage

// >>> verilog/fault_input_filter.sv
// synchroniser and minimum-width filter for one fault input
`timescale 1ns/1ps
module fault_input_filter (
  // clock and reset
  input  wire logic                              clock,
  input  wire logic                              rst_b,
  // fault input and filter setting
  input  wire logic                              event_in,
  input  wire logic [pwm_fault_pkg::FILT_W-1:0] filter_length,
  // filtered fault level
  output logic                                   event_out
);
  logic                              sync1;
  logic                              sync2;
  logic [pwm_fault_pkg::FILT_W-1:0] run;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync1 <= 1'h0;
      sync2 <= 1'h0;
    end
    else
    begin
      sync1 <= event_in;
      sync2 <= sync1;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run       <= '0;
      event_out <= 1'h0;
    end
    else if (!sync2)
    begin
      run       <= '0;
      event_out <= 1'h0;
    end
    else
    begin
      if (run != filter_length)
        run <= run + 1'h1;
      event_out <= (run == filter_length);
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_filter_length;
    $rose(event_out) |-> $past(sync2) && $past(run) == $past(filter_length);
  endproperty
  a_filter_length: assert property (p_filter_length) else $error("filter released early");
endmodule // fault_input_filter

// >>> verilog/fault_capture_unit.sv
// capture register, match flag and overrun flag of one channel
`timescale 1ns/1ps
module fault_capture_unit (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // capture control
  input  wire logic [2:0]  capture_mode,
  input  wire logic        capture_event,
  input  wire logic [15:0] count_value,
  input  wire logic        counter_wrap,
  // software access
  input  wire logic        compare_write,
  input  wire logic [15:0] compare_write_value,
  input  wire logic        match_flag_clear,
  input  wire logic        capture_error_clear,
  // channel state
  output logic [15:0]      channel_compare_value,
  output logic             channel_match_flag,
  output logic             capture_error
);
  logic        load;
  logic        set_flag;
  logic        set_error;
  logic        overflow_seen;
  logic [15:0] load_value;

  always_comb
  begin
    load      = 1'h0;
    set_flag  = 1'h0;
    set_error = 1'h0;
    case (capture_mode)
      pwm_fault_pkg::PLAIN_FAULT_CAPTURE_PLAIN:
      begin
        load     = capture_event;
        set_flag = capture_event;
      end
      pwm_fault_pkg::PLAIN_FAULT_CAPTURE_MIN:
      begin
        load     = capture_event && (count_value < channel_compare_value);
        set_flag = load;
      end
      pwm_fault_pkg::PLAIN_FAULT_CAPTURE_MAX:
      begin
        load     = capture_event && (count_value > channel_compare_value);
        set_flag = load;
      end
      pwm_fault_pkg::PLAIN_FAULT_CAPTURE_LOCAL_MINIMUM_NOTIFY:
      begin
        load     = capture_event;
        set_flag = capture_event && (count_value >= channel_compare_value);
      end
      pwm_fault_pkg::PLAIN_FAULT_CAPTURE_LOCAL_MAXIMUM_NOTIFY:
      begin
        load     = capture_event;
        set_flag = capture_event && (count_value <= channel_compare_value);
      end
      pwm_fault_pkg::PLAIN_FAULT_CAPTURE_LOCEXT:
      begin
        load     = capture_event;
        set_flag = capture_event && ((count_value >= channel_compare_value)
                   || (count_value <= channel_compare_value));
      end
      pwm_fault_pkg::PLAIN_FAULT_CAPTURE_STAMP:
      begin
        load      = capture_event && !channel_match_flag;
        set_flag  = load;
        set_error = capture_event && channel_match_flag;
      end
      default:
      begin
        load = 1'h0;
      end
    endcase
  end

  assign load_value = (capture_mode == pwm_fault_pkg::PLAIN_FAULT_CAPTURE_STAMP && overflow_seen)
                      ? pwm_fault_pkg::COUNT_MAX : count_value;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      channel_compare_value <= pwm_fault_pkg::COUNT_RESET;
    else if (load)
      channel_compare_value <= load_value;
    else if (compare_write)
      channel_compare_value <= compare_write_value;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      overflow_seen <= 1'h0;
    else if (load)
      overflow_seen <= 1'h0;
    else if (counter_wrap)
      overflow_seen <= 1'h1;
  end

  // set wins over software clear
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      channel_match_flag <= 1'h0;
      capture_error      <= 1'h0;
    end
    else
    begin
      if (set_flag)
        channel_match_flag <= 1'h1;
      else if (match_flag_clear)
        channel_match_flag <= 1'h0;
      if (set_error)
        capture_error <= 1'h1;
      else if (capture_error_clear)
        capture_error <= 1'h0;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_stamp_overrun;
    capture_mode == pwm_fault_pkg::PLAIN_FAULT_CAPTURE_STAMP && capture_event && channel_match_flag
    |=> capture_error && $stable(channel_compare_value);
  endproperty
  a_stamp_overrun: assert property (p_stamp_overrun) else $error("overrun not flagged");

  property p_min_keeps;
    capture_mode == pwm_fault_pkg::PLAIN_FAULT_CAPTURE_MIN && capture_event && !compare_write
    && count_value >= channel_compare_value |=> $stable(channel_compare_value);
  endproperty
  a_min_keeps: assert property (p_min_keeps) else $error("minimum overwritten");

  property p_plain_capture;
    capture_mode == pwm_fault_pkg::PLAIN_FAULT_CAPTURE_PLAIN && capture_event
    |=> channel_compare_value == $past(count_value) && channel_match_flag;
  endproperty
  a_plain_capture: assert property (p_plain_capture) else $error("plain capture lost");

  c_stamp_overrun: cover property (p_stamp_overrun);
endmodule // fault_capture_unit

// >>> verilog/pwm_fault_action_capture.sv
// recoverable and non-recoverable fault actions with fault capture
`timescale 1ns/1ps
// Functional notes
// - keep option clamps the channel output to zero while the fault lasts
// - keep clamp releases at the first cycle start after the fault is gone
// - restart option aborts the running cycle and starts a new one
// - single-ramp restart keeps outputs inactive while the fault persists
// - two-ramp modes toggle the ramp index at every cycle start
// - two-ramp: fault A counts only in cycle A, fault B in B
// - fault capture action stores the counter at the fault moment
// - min/max capture keeps the extremum and flags only new extrema
// - local notify modes load the counter at every capture event
// - local min flags on greater-or-equal, local max on less-or-equal, extreme both
// - extremum capture needs a nonzero or non-top preload, else never captures
// - plain capture stores and flags on every capture event
// - hardware halt freezes the counter while the fault lasts
// - hardware halt clamps output, then resumes or restarts when fault ends
// - software halt ends only when fault is gone and status cleared
// - non-recoverable fault drives enabled outputs to programmed levels
// - non-recoverable input filter synchronises and delays by programmed cycles
// - debug break with its enable raises the debug fault state
// - locked update with index or direction change raises update fault
// - time stamp stores counter, or maximum after overflow, and flags
// - stamp while flag set is discarded and sets the error flag
// - fault A comes from channel 0 event, fault B from channel 1
// - qualification ignores a fault while its channel output is inactive
// - recoverable filter drops short events and delays valid ones
module pwm_fault_action_capture (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // asynchronous event inputs
  input  wire logic        channel0_input_event,
  input  wire logic        channel1_input_event,
  input  wire logic        nonrec_event0,
  input  wire logic        nonrec_event1,
  // recoverable fault configuration, bit 0 fault A, bit 1 fault B
  input  wire logic [1:0]  fault_keep,
  input  wire logic [1:0]  fault_restart,
  input  wire logic [1:0]  fault_qualify,
  input  wire logic [1:0]  fault_halt_mode_a,
  input  wire logic [1:0]  fault_halt_mode_b,
  input  wire logic [2:0]  fault_capture_mode_a,
  input  wire logic [2:0]  fault_capture_mode_b,
  input  wire logic [3:0]  fault_filter_length_a,
  input  wire logic [3:0]  fault_filter_length_b,
  // software strobes
  input  wire logic [1:0]  fault_status_clear,
  input  wire logic [1:0]  match_flag_clear,
  input  wire logic [1:0]  capture_error_clear,
  input  wire logic [1:0]  compare_write,
  input  wire logic [15:0] compare_write_value,
  input  wire logic        nonrec_state_clear,
  // counter configuration
  input  wire logic [15:0] counter_top,
  input  wire logic [1:0]  ramp_mode,
  input  wire logic        dual_slope_both_update,
  input  wire logic        count_direction,
  input  wire logic        lock_buffer_update,
  // non-recoverable configuration
  input  wire logic [1:0]  event_action_select,
  input  wire logic [3:0]  nonrec_input_filter_length0,
  input  wire logic [3:0]  nonrec_input_filter_length1,
  input  wire logic [1:0]  nonrec_override_enable,
  input  wire logic [1:0]  nonrec_override_value,
  input  wire logic        fault_on_debug_break,
  input  wire logic        debug_mode,
  // waveform and status
  output logic [1:0]       wave_out,
  output logic [15:0]      count_value,
  output logic             ramp_index,
  output logic             counter_halted,
  output logic [1:0]       recoverable_fault_status,
  output logic             nonrec_fault_active,
  output logic             debug_fault_state,
  output logic             update_fault_state,
  // capture channels
  output logic [15:0]      channel0_compare_value,
  output logic [15:0]      channel1_compare_value,
  output logic [1:0]       channel_match_flag,
  output logic [1:0]       capture_error
);
  pwm_fault_pkg::halt_state_type state;
  logic [1:0]  filt;
  logic [1:0]  nonrec_filt;
  logic [1:0]  qual_fault;
  logic [1:0]  qual_prev;
  logic [1:0]  fault_rise;
  logic [1:0]  window_ok;
  logic [1:0]  wave_raw;
  logic [1:0]  halt_req;
  logic [1:0]  keep_clamp;
  logic [1:0]  clamp;
  logic [1:0]  next_wave;
  logic [1:0]  halt_mode [2];
  logic [2:0]  capture_mode [2];
  logic [15:0] compare_value [2];
  logic        two_ramp;
  logic        halting;
  logic        halt_restart;
  logic        restart_now;
  logic        cycle_start;
  logic        counter_wrap;
  logic        restart_clamp;
  logic        nonrec_now;
  logic        dir_prev;

  assign two_ramp        = (ramp_mode == pwm_fault_pkg::RAMP_TWO)
                           || (ramp_mode == pwm_fault_pkg::RAMP_ALT);
  assign halt_mode[0]    = fault_halt_mode_a;
  assign halt_mode[1]    = fault_halt_mode_b;
  assign capture_mode[0] = fault_capture_mode_a;
  assign capture_mode[1] = fault_capture_mode_b;
  assign channel0_compare_value = compare_value[0];
  assign channel1_compare_value = compare_value[1];

  // fault A, fault B and non-recoverable event input filters
  fault_input_filter filter_a (
    .clock         (clock),
    .rst_b         (rst_b),
    .event_in      (channel0_input_event),
    .filter_length (fault_filter_length_a),
    .event_out     (filt[0])
  );
  fault_input_filter filter_b (
    .clock         (clock),
    .rst_b         (rst_b),
    .event_in      (channel1_input_event),
    .filter_length (fault_filter_length_b),
    .event_out     (filt[1])
  );
  fault_input_filter filter_nr0 (
    .clock         (clock),
    .rst_b         (rst_b),
    .event_in      (nonrec_event0),
    .filter_length (nonrec_input_filter_length0),
    .event_out     (nonrec_filt[0])
  );
  fault_input_filter filter_nr1 (
    .clock         (clock),
    .rst_b         (rst_b),
    .event_in      (nonrec_event1),
    .filter_length (nonrec_input_filter_length1),
    .event_out     (nonrec_filt[1])
  );

  // compare waveforms; two-ramp gates odd or even channel
  always_comb
  begin
    wave_raw[0] = count_value < channel0_compare_value;
    wave_raw[1] = (ramp_mode == pwm_fault_pkg::RAMP_ALT) ? wave_raw[0]
                  : (count_value < channel1_compare_value);
    if (two_ramp)
      wave_raw = wave_raw & {ramp_index, ~ramp_index};
  end

  assign window_ok = two_ramp ? {ramp_index, ~ramp_index} : 2'h3;

  genvar f;
  generate
    for (f = 0; f < 2; f++)
    begin : g_fault
      assign qual_fault[f] = filt[f] && window_ok[f] && (!fault_qualify[f] || wave_raw[f]);
      assign fault_rise[f] = qual_fault[f] && !qual_prev[f];
      assign halt_req[f] = ((halt_mode[f] == pwm_fault_pkg::HALT_HW) && qual_fault[f])
                           || ((halt_mode[f] == pwm_fault_pkg::HALT_SW)
                           && (qual_fault[f] || recoverable_fault_status[f]));
      assign clamp[f] = keep_clamp[f] || (fault_keep[f] && qual_fault[f]) || halt_req[f]
                        || restart_clamp;

      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
          keep_clamp[f] <= 1'h0;
        else if (fault_keep[f] && qual_fault[f])
          keep_clamp[f] <= 1'h1;
        else if (cycle_start)
          keep_clamp[f] <= 1'h0;
      end

      always_ff @(posedge clock or negedge rst_b)
      begin
        if (!rst_b)
          recoverable_fault_status[f] <= 1'h0;
        else if (qual_fault[f])
          recoverable_fault_status[f] <= 1'h1;
        else if (fault_status_clear[f])
          recoverable_fault_status[f] <= 1'h0;
      end

      fault_capture_unit capture (
        .clock                 (clock),
        .rst_b                 (rst_b),
        .capture_mode          (capture_mode[f]),
        .capture_event         (fault_rise[f]),
        .count_value           (count_value),
        .counter_wrap          (counter_wrap),
        .compare_write         (compare_write[f]),
        .compare_write_value   (compare_write_value),
        .match_flag_clear      (match_flag_clear[f]),
        .capture_error_clear   (capture_error_clear[f]),
        .channel_compare_value (compare_value[f]),
        .channel_match_flag    (channel_match_flag[f]),
        .capture_error         (capture_error[f])
      );
    end
  endgenerate

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      qual_prev <= 2'h0;
    else
      qual_prev <= qual_fault;
  end

  assign restart_clamp = (ramp_mode == pwm_fault_pkg::RAMP_SINGLE)
                         && |(qual_fault & fault_restart);

  // restart on fault or halt exit
  assign halting      = (state == pwm_fault_pkg::st_halt) || |halt_req;
  assign restart_now  = |(fault_rise & fault_restart)
                        || ((state == pwm_fault_pkg::st_halt) && !(|halt_req) && halt_restart);
  assign counter_wrap = !halting && !restart_now && (count_value == counter_top);
  assign cycle_start  = restart_now || counter_wrap;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state          <= pwm_fault_pkg::st_count;
      halt_restart   <= 1'h0;
      counter_halted <= 1'h0;
    end
    else
    begin
      counter_halted <= |halt_req;
      case (state)
        pwm_fault_pkg::st_count:
          if (|halt_req)
          begin
            state        <= pwm_fault_pkg::st_halt;
            halt_restart <= |(halt_req & fault_restart);
          end
        pwm_fault_pkg::st_halt:
          if (!(|halt_req))
            state <= pwm_fault_pkg::st_count;
        default:
          state <= pwm_fault_pkg::st_count;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      count_value <= pwm_fault_pkg::COUNT_RESET;
    else if (restart_now || counter_wrap)
      count_value <= pwm_fault_pkg::COUNT_RESET;
    else if (!halting)
      count_value <= count_value + 16'h0001;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      ramp_index <= 1'h0;
    else if (two_ramp && cycle_start)
      ramp_index <= ~ramp_index;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      debug_fault_state  <= 1'h0;
      update_fault_state <= 1'h0;
      dir_prev           <= 1'h0;
    end
    else
    begin
      dir_prev <= count_direction;
      if (fault_on_debug_break && debug_mode)
        debug_fault_state <= 1'h1;
      else if (nonrec_state_clear)
        debug_fault_state <= 1'h0;
      if (lock_buffer_update && (two_ramp || dual_slope_both_update)
          && ((two_ramp && cycle_start) || (count_direction != dir_prev)))
        update_fault_state <= 1'h1;
      else if (nonrec_state_clear)
        update_fault_state <= 1'h0;
    end
  end

  assign nonrec_now = |(nonrec_filt & event_action_select) || debug_fault_state
                      || update_fault_state;
  always_comb
  begin
    next_wave = wave_raw & ~clamp;
    if (nonrec_now)
      next_wave = (next_wave & ~nonrec_override_enable)
                  | (nonrec_override_value & nonrec_override_enable);
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wave_out            <= 2'h0;
      nonrec_fault_active <= 1'h0;
    end
    else
    begin
      wave_out            <= next_wave;
      nonrec_fault_active <= nonrec_now;
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_keep_zero;
    fault_keep[0] && qual_fault[0] && !nonrec_now |=> !wave_out[0];
  endproperty
  a_keep_zero: assert property (p_keep_zero) else $error("keep did not clamp");

  property p_restart_count;
    fault_rise[0] && fault_restart[0] |=> count_value == 16'h0000;
  endproperty
  a_restart_count: assert property (p_restart_count) else $error("restart missed");

  property p_halt_freeze;
    |halt_req && !restart_now && !counter_wrap |=> $stable(count_value);
  endproperty
  a_halt_freeze: assert property (p_halt_freeze) else $error("counter moved in halt");

  property p_ramp_toggle;
    two_ramp && cycle_start |=> ramp_index != $past(ramp_index);
  endproperty
  a_ramp_toggle: assert property (p_ramp_toggle) else $error("ramp index stuck");

  property p_ramp_window;
    two_ramp && ramp_index |-> !qual_fault[0];
  endproperty
  a_ramp_window: assert property (p_ramp_window) else $error("fault A in cycle B");

  property p_nonrec_level;
    nonrec_fault_active && $past(nonrec_override_enable[1])
    |-> wave_out[1] == $past(nonrec_override_value[1]);
  endproperty
  a_nonrec_level: assert property (p_nonrec_level) else $error("override level wrong");

  property p_debug_fault;
    fault_on_debug_break && debug_mode |=> debug_fault_state ##1 nonrec_fault_active;
  endproperty
  a_debug_fault: assert property (p_debug_fault) else $error("debug fault missed");

  c_restart: cover property (p_restart_count);
  c_halt: cover property (state == pwm_fault_pkg::st_halt ##1 state == pwm_fault_pkg::st_count);
  c_nonrec: cover property ($rose(nonrec_fault_active));
endmodule // pwm_fault_action_capture

// >>> bench/fault_source_model.sv
// event system and power stage model driving the fault inputs
`timescale 1ns/1ps
module fault_source_model #(
  parameter time LAG = 3
) (
  // requests from the bench
  input  wire logic [1:0] fire,
  input  wire logic [1:0] nr_fire,
  // asynchronous fault levels
  output logic            channel0_input_event,
  output logic            channel1_input_event,
  output logic            nonrec_event0,
  output logic            nonrec_event1
);
  assign #LAG channel0_input_event = fire[0];
  assign #LAG channel1_input_event = fire[1];
  assign #LAG nonrec_event0 = nr_fire[0];
  assign #LAG nonrec_event1 = nr_fire[1];
endmodule // fault_source_model

// >>> bench/pwm_fault_action_capture_tb.sv
// self-checking bench of the fault action and capture block
`timescale 1ns/1ps
module pwm_fault_action_capture_tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic channel0_input_event, channel1_input_event, nonrec_event0, nonrec_event1;
  logic [1:0] fault_keep = 0, fault_restart = 0, fault_qualify = 0, fault_halt_mode_a = 0;
  logic [1:0] fault_halt_mode_b = 0, fault_status_clear = 0, match_flag_clear = 0;
  logic [1:0] capture_error_clear = 0, compare_write = 0, ramp_mode = 0, fire = 0, nr_fire = 0;
  logic [1:0] event_action_select = 0, nonrec_override_enable = 0, nonrec_override_value = 0;
  logic [2:0] fault_capture_mode_a = 0, fault_capture_mode_b = 0;
  logic [3:0] fault_filter_length_a = 0, fault_filter_length_b = 0;
  logic [3:0] nonrec_input_filter_length0 = 0, nonrec_input_filter_length1 = 0;
  logic [15:0] compare_write_value = 0, counter_top = 16'h0040, snap;
  logic nonrec_state_clear = 0, dual_slope_both_update = 0, count_direction = 0;
  logic lock_buffer_update = 0, fault_on_debug_break = 0, debug_mode = 0;
  logic [1:0] wave_out, recoverable_fault_status, channel_match_flag, capture_error;
  logic [15:0] count_value, channel0_compare_value, channel1_compare_value;
  logic ramp_index, counter_halted, nonrec_fault_active, debug_fault_state, update_fault_state;
  int err_total = 0, checks_done = 0, cyc = 0, seed = 32'h1810;
  fault_source_model fault_source_model_inst (.fire, .nr_fire, .channel0_input_event,
    .channel1_input_event, .nonrec_event0, .nonrec_event1);
  pwm_fault_action_capture pwm_fault_action_capture_inst (.clock, .rst_b,
    .channel0_input_event, .channel1_input_event, .nonrec_event0, .nonrec_event1,
    .fault_keep, .fault_restart, .fault_qualify, .fault_halt_mode_a, .fault_halt_mode_b,
    .fault_capture_mode_a, .fault_capture_mode_b, .fault_filter_length_a,
    .fault_filter_length_b, .fault_status_clear, .match_flag_clear, .capture_error_clear,
    .compare_write, .compare_write_value, .nonrec_state_clear, .counter_top, .ramp_mode,
    .dual_slope_both_update, .count_direction, .lock_buffer_update, .event_action_select,
    .nonrec_input_filter_length0, .nonrec_input_filter_length1, .nonrec_override_enable,
    .nonrec_override_value, .fault_on_debug_break, .debug_mode, .wave_out, .count_value,
    .ramp_index, .counter_halted, .recoverable_fault_status, .nonrec_fault_active,
    .debug_fault_state, .update_fault_state, .channel0_compare_value,
    .channel1_compare_value, .channel_match_flag, .capture_error);
  always #25 clock = ~clock;
  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      conclude();
    end
  end
  initial
  begin
    step(5);
    chk(count_value, 16'h0000);
    step(1);
    rst_b = 1'b1;
    counter_top = 16'h0020 + 16'($unsigned($random(seed)) % 32);
    compare_write = 2'b11;
    compare_write_value = counter_top >> 1;
    fault_restart = 2'b01;
    fault_filter_length_a = 4'h4;
    step(1);
    compare_write = 2'b00;
    step(20);
    fire = 2'b01;
    step(2);
    fire = 2'b00;
    step(8);
    chk(16'(recoverable_fault_status[0]), 16'h0000);
    fault_filter_length_a = 4'h0;
    fire = 2'b01;
    step(5);
    chk(16'(count_value < 16'h0004), 16'h0001);
    step(30);
    chk(16'(wave_out[0]), 16'h0000);
    fire = 2'b00;
    fault_restart = 2'b00;
    fault_status_clear = 2'b11;
    step(1);
    fault_status_clear = 2'b00;
    $display("restart test done");
    fault_halt_mode_a = pwm_fault_pkg::HALT_HW;
    fire = 2'b01;
    step(6);
    snap = count_value;
    step(5);
    chk(count_value, snap);
    chk(16'(counter_halted), 16'h0001);
    chk(16'(wave_out[0]), 16'h0000);
    fire = 2'b00;
    step(8);
    chk(16'(count_value != snap), 16'h0001);
    fault_halt_mode_a = pwm_fault_pkg::HALT_OFF;
    $display("halt test done");
    fault_capture_mode_b = pwm_fault_pkg::PLAIN_FAULT_CAPTURE_STAMP;
    fire = 2'b10;
    step(6);
    fire = 2'b00;
    step(3);
    chk(16'(channel_match_flag[1]), 16'h0001);
    snap = channel1_compare_value;
    fire = 2'b10;
    step(6);
    fire = 2'b00;
    step(3);
    chk(channel1_compare_value, snap);
    chk(16'(capture_error[1]), 16'h0001);
    compare_write = 2'b01;
    compare_write_value = 16'h0000;
    fault_capture_mode_a = pwm_fault_pkg::PLAIN_FAULT_CAPTURE_MIN;
    step(1);
    compare_write = 2'b00;
    fire = 2'b01;
    step(6);
    fire = 2'b00;
    step(3);
    chk(channel0_compare_value, 16'h0000);
    chk(16'(channel_match_flag[0]), 16'h0000);
    $display("capture test done");
    fault_capture_mode_a = pwm_fault_pkg::PLAIN_FAULT_CAPTURE_NONE;
    fault_keep = 2'b01;
    compare_write = 2'b01;
    compare_write_value = 16'hffff;
    step(1);
    compare_write = 2'b00;
    fire = 2'b01;
    step(8);
    chk(16'(wave_out[0]), 16'h0000);
    fire = 2'b00;
    step(70);
    chk(16'(wave_out[0]), 16'h0001);
    fault_keep = 2'b00;
    $display("keep test done");
    fault_capture_mode_b = pwm_fault_pkg::PLAIN_FAULT_CAPTURE_PLAIN;
    match_flag_clear = 2'b10;
    step(1);
    match_flag_clear = 2'b00;
    chk(16'(channel_match_flag[1]), 16'h0000);
    fire = 2'b10;
    step(6);
    chk(16'(channel_match_flag[1]), 16'h0001);
    fire = 2'b00;
    step(4);
    $display("plain capture test done");
    ramp_mode = pwm_fault_pkg::RAMP_TWO;
    lock_buffer_update = 1'b1;
    while (count_value != 16'h0001) step(1);
    snap = 16'(ramp_index);
    step(1);
    while (count_value != 16'h0001) step(1);
    chk(16'(ramp_index ^ snap[0]), 16'h0001);
    chk(16'(update_fault_state), 16'h0001);
    lock_buffer_update = 1'b0;
    ramp_mode = pwm_fault_pkg::RAMP_SINGLE;
    nonrec_state_clear = 1'b1;
    step(1);
    nonrec_state_clear = 1'b0;
    $display("ramp test done");
    event_action_select = 2'b01;
    nonrec_override_enable = 2'b11;
    nonrec_override_value = 2'($random(seed));
    nr_fire = 2'b01;
    step(6);
    chk(16'(wave_out), 16'(nonrec_override_value));
    chk(16'(nonrec_fault_active), 16'h0001);
    nr_fire = 2'b00;
    fault_on_debug_break = 1'b1;
    debug_mode = 1'b1;
    step(2);
    chk(16'(debug_fault_state), 16'h0001);
    $display("nonrecoverable test done");
    conclude();
  end
endmodule // pwm_fault_action_capture_tb
